// File: hdl/tos_edge_det.sv
`default_nettype none

module tos_edge_det (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_trigger_signal,
  tos_tick_if.edg t
);
  logic ext_q;
  logic rise_q;
  logic fall_q;
  logic rise;
  logic fall;

  assign rise = ext_trigger_signal & ~ext_q;
  assign fall = ~ext_trigger_signal & ext_q;

  // edges held until the next tick; new edge beats consume
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      ext_q <= ext_trigger_signal;
      if (t.flush) begin
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        rise_q <= rise | (rise_q & ~t.tick);
        fall_q <= fall | (fall_q & ~t.tick);
      end
    end
  end

  assign t.rise_pend = rise_q;
  assign t.fall_pend = fall_q;
  assign t.level = ext_q;
endmodule : tos_edge_det

`default_nettype wire

// File: hdl/tos_prescaler.sv
`default_nettype none

module tos_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tos_pkg::PRE_W-1:0] prescale_select,
  tos_tick_if.pre t
);
  logic [tos_pkg::PRE_CNT_W-1:0] cnt_q;
  logic [tos_pkg::PRE_CNT_W-1:0] lim;
  logic tick_q;

  // ratio 1:2^select
  assign lim = tos_pkg::PRE_CNT_W'((1 << prescale_select) - 1);

  // divider, restarted by clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (t.clear) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == lim);
      cnt_q <= (cnt_q == lim) ? '0 : cnt_q + 1'b1;
    end
  end

  assign t.tick = tick_q;
endmodule : tos_prescaler

`default_nettype wire

// File: hdl/tos_timer.sv
`default_nettype none

module tos_timer #(
  parameter int CNT_W = tos_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tos_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tos_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_trigger_signal,
  output logic postscaled_pulse,
  output logic timer_irq
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [tos_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  logic run_q;
  logic armed_q;
  logic [tos_pkg::PRE_W-1:0] prescale_select_q;
  logic [tos_pkg::POST_W-1:0] postscale_select_q;
  logic [tos_pkg::MODE_W-1:0] mode_q;
  logic [CNT_W-1:0] count_value_q;
  logic [CNT_W-1:0] period_value_q;
  logic [tos_pkg::POST_W-1:0] post_cnt_q;
  logic postscaled_pulse_q;
  logic [tos_pkg::SYNC_STAGES-1:0] flag_dly_q;
  logic [tos_pkg::IRQ_W-1:0] irq_status_q;
  logic [tos_pkg::IRQ_W-1:0] periph_irq_enable_reg_q;
  logic timer_irq_q;

  logic wr_fire;
  logic wr_lane;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_count;
  logic wr_period;
  logic wr_clear;
  logic wr_enable;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] rd_word;

  logic [1:0] fam;
  logic [2:0] sub;
  logic mode_ok;
  logic start_c;
  logic hwrst_c;
  logic keep_arm_c;
  logic one_shot_c;
  logic stop_c;
  logic active;
  logic match_c;
  logic post_hit;
  logic [tos_pkg::IRQ_W-1:0] irq_set;
  logic [tos_pkg::IRQ_W-1:0] irq_clr;

  tos_tick_if t ();

  // ****************************************************
  // submodules
  // ****************************************************
  tos_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .prescale_select(prescale_select_q),
    .t(t.pre)
  );

  tos_edge_det u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_trigger_signal(ext_trigger_signal),
    .t(t.edg)
  );

  // ****************************************************
  // axi4-lite write channel
  // ****************************************************

  // address and data latched in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= tos_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? tos_pkg::RESP_OKAY : tos_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // write decode, low byte lane carries every field
  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_lane = wr_fire & wstrb_q[0];
  assign wr_ctrl = wr_lane & (awaddr_q == tos_pkg::OFF_CTRL);
  assign wr_mode = wr_lane & (awaddr_q == tos_pkg::OFF_MODE);
  assign wr_count = wr_lane & (awaddr_q == tos_pkg::OFF_COUNT);
  assign wr_period = wr_lane & (awaddr_q == tos_pkg::OFF_PERIOD);
  assign wr_clear = wr_lane & (awaddr_q == tos_pkg::OFF_IRQ_CLEAR);
  assign wr_enable = wr_lane & (awaddr_q == tos_pkg::OFF_IRQ_ENABLE);
  assign wr_mapped = (awaddr_q == tos_pkg::OFF_CTRL) | (awaddr_q == tos_pkg::OFF_MODE)
                   | (awaddr_q == tos_pkg::OFF_COUNT) | (awaddr_q == tos_pkg::OFF_PERIOD)
                   | (awaddr_q == tos_pkg::OFF_IRQ_STATUS)
                   | (awaddr_q == tos_pkg::OFF_IRQ_CLEAR)
                   | (awaddr_q == tos_pkg::OFF_IRQ_ENABLE)
                   | (awaddr_q == tos_pkg::OFF_STATE);

  // ****************************************************
  // axi4-lite read channel
  // ****************************************************

  // read word mux, unused bits zero
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    case (araddr)
      tos_pkg::OFF_CTRL: begin
        rd_word[tos_pkg::CTRL_ON_BIT] = run_q;
        rd_word[tos_pkg::CTRL_PRE_LSB +: tos_pkg::PRE_W] = prescale_select_q;
        rd_word[tos_pkg::CTRL_POST_LSB +: tos_pkg::POST_W] = postscale_select_q;
      end
      tos_pkg::OFF_MODE: rd_word[tos_pkg::MODE_W-1:0] = mode_q;
      tos_pkg::OFF_COUNT: rd_word[CNT_W-1:0] = count_value_q;
      tos_pkg::OFF_PERIOD: rd_word[CNT_W-1:0] = period_value_q;
      tos_pkg::OFF_IRQ_STATUS: rd_word[tos_pkg::IRQ_W-1:0] = irq_status_q;
      tos_pkg::OFF_IRQ_CLEAR: rd_word = '0; // write-only
      tos_pkg::OFF_IRQ_ENABLE: rd_word[tos_pkg::IRQ_W-1:0] = periph_irq_enable_reg_q;
      tos_pkg::OFF_STATE: begin
        rd_word[tos_pkg::STATE_ARMED_BIT] = armed_q;
        rd_word[tos_pkg::STATE_LEVEL_BIT] = t.level;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  // one read at a time, answer one edge after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= tos_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? tos_pkg::RESP_OKAY : tos_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ****************************************************
  // software configuration
  // ****************************************************

  // control, mode, period and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_select_q <= '0;
      postscale_select_q <= '0;
      mode_q <= '0;
      period_value_q <= '1;
      periph_irq_enable_reg_q <= '0;
    end else begin
      if (wr_ctrl) begin
        prescale_select_q <= wdata_q[tos_pkg::CTRL_PRE_LSB +: tos_pkg::PRE_W];
        postscale_select_q <= wdata_q[tos_pkg::CTRL_POST_LSB +: tos_pkg::POST_W];
      end
      if (wr_mode) begin
        mode_q <= wdata_q[tos_pkg::MODE_W-1:0];
      end
      if (wr_period) begin
        period_value_q <= wdata_q[CNT_W-1:0];
      end
      if (wr_enable) begin
        periph_irq_enable_reg_q <= wdata_q[tos_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************
  // mode decode
  // ****************************************************

  // start, reset and stop terms per mode
  always_comb begin
    fam = mode_q[tos_pkg::MODE_W-1:tos_pkg::SUB_W];
    sub = mode_q[tos_pkg::SUB_W-1:0];
    mode_ok = 1'b0;
    start_c = 1'b0;
    hwrst_c = 1'b0;
    keep_arm_c = 1'b0;
    one_shot_c = 1'b0;
    stop_c = 1'b0;
    case (fam)
      tos_pkg::FAM_FREE: begin
        mode_ok = 1'b1;
        start_c = 1'b1;
      end
      tos_pkg::FAM_ONE: begin
        mode_ok = 1'b1;
        one_shot_c = 1'b1;
        stop_c = 1'b1;
        case (sub)
          tos_pkg::SUB_SW: start_c = 1'b1;
          tos_pkg::SUB_RISE, tos_pkg::SUB_RISE_RST, tos_pkg::SUB_RISE_LO:
            start_c = t.rise_pend;
          tos_pkg::SUB_FALL, tos_pkg::SUB_FALL_RST, tos_pkg::SUB_FALL_HI:
            start_c = t.fall_pend;
          default: start_c = t.rise_pend | t.fall_pend;
        endcase
        case (sub)
          tos_pkg::SUB_RISE_RST: begin
            hwrst_c = t.rise_pend;
            keep_arm_c = 1'b1;
          end
          tos_pkg::SUB_FALL_RST: begin
            hwrst_c = t.fall_pend;
            keep_arm_c = 1'b1;
          end
          tos_pkg::SUB_RISE_LO: hwrst_c = ~t.level;
          tos_pkg::SUB_FALL_HI: hwrst_c = t.level;
          default: hwrst_c = 1'b0;
        endcase
      end
      tos_pkg::FAM_MONO: begin
        case (sub)
          tos_pkg::SUB_RISE, tos_pkg::SUB_FALL, tos_pkg::SUB_ANY: begin
            mode_ok = 1'b1;
            stop_c = 1'b1;
            start_c = (sub != tos_pkg::SUB_FALL) & t.rise_pend
                    | (sub != tos_pkg::SUB_RISE) & t.fall_pend;
          end
          tos_pkg::SUB_RISE_LO: begin
            mode_ok = 1'b1;
            one_shot_c = 1'b1;
            stop_c = 1'b1;
            start_c = t.level;
            hwrst_c = ~t.level;
          end
          tos_pkg::SUB_FALL_HI: begin
            mode_ok = 1'b1;
            one_shot_c = 1'b1;
            stop_c = 1'b1;
            start_c = ~t.level;
            hwrst_c = t.level;
          end
          default: mode_ok = 1'b0;
        endcase
      end
      default: mode_ok = 1'b0;
    endcase
  end

  assign active = t.tick & run_q & mode_ok;
  assign match_c = active & ~hwrst_c & armed_q & (count_value_q == period_value_q);

  // scaler restart on control and count writes and external reset
  assign t.clear = wr_ctrl | wr_count | (active & hwrst_c);
  assign t.flush = ~run_q;

  // ****************************************************
  // counter core
  // ****************************************************

  // count, arm and stop per prescaled tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_q <= '0;
      armed_q <= 1'b0;
    end else if (wr_count) begin
      count_value_q <= wdata_q[CNT_W-1:0];
    end else if (!run_q) begin
      armed_q <= 1'b0;
    end else if (active) begin
      if (hwrst_c) begin
        count_value_q <= '0;
        armed_q <= keep_arm_c;
      end else if (!armed_q) begin
        armed_q <= start_c;
      end else if (match_c) begin
        count_value_q <= '0;
        armed_q <= ~stop_c;
      end else begin
        count_value_q <= count_value_q + 1'b1;
      end
    end
  end

  // run bit: software write, cleared by one-shot match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= wdata_q[tos_pkg::CTRL_ON_BIT];
    end else if (match_c && one_shot_c) begin
      run_q <= 1'b0;
    end
  end

  // ****************************************************
  // postscaler and interrupt
  // ****************************************************

  assign post_hit = match_c & (post_cnt_q == postscale_select_q);

  // postscale counter, ratio select+1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_cnt_q <= '0;
      postscaled_pulse_q <= 1'b0;
    end else begin
      postscaled_pulse_q <= post_hit;
      if (t.clear || post_hit) begin
        post_cnt_q <= '0;
      end else if (match_c) begin
        post_cnt_q <= post_cnt_q + 1'b1;
      end
    end
  end

  // two-cycle delay from pulse to the flag set term
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_dly_q <= '0;
    end else begin
      flag_dly_q <= {flag_dly_q[tos_pkg::SYNC_STAGES-2:0], postscaled_pulse_q};
    end
  end

  // sticky status, set beats clear
  always_comb begin
    irq_set = '0;
    irq_set[tos_pkg::IRQ_FLAG_BIT] = flag_dly_q[tos_pkg::SYNC_STAGES-1];
    irq_set[tos_pkg::IRQ_MATCH_BIT] = match_c;
    irq_clr = wr_clear ? wdata_q[tos_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
      timer_irq_q <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      timer_irq_q <= |(irq_status_q & periph_irq_enable_reg_q);
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign postscaled_pulse = postscaled_pulse_q;
  assign timer_irq = timer_irq_q;

endmodule : tos_timer

`default_nettype wire

// File: inc/tos_pkg.sv
// Operation
// - five-bit mode: family high, variant low
// - count per prescaled tick, clear after match
// - one-shot starts on run plus chosen edge, variant 000 on run alone
// - modes 100/101 same edge restarts count
// - mode 110/111 edge start, level reset
// - one-shot match clears run, count zero
// - edge monostable match stops count, run kept
// - level modes start/reset by input level
// - run cleared needs fresh edge to restart
// - flag interrupt at postscale ratio 1:1 to 1:16, match interrupt on every match
// - interrupt forwarded only when enabled
// - flag set three cycles after postscaled pulse
`default_nettype none

package tos_pkg;

  // ****************************************************
  // register map, byte addresses
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_STATE = 8'h1C;

  // ****************************************************
  // field layout
  // ****************************************************
  localparam int CNT_W = 8;
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_PRE_LSB = 4;
  localparam int PRE_W = 3;
  localparam int PRE_CNT_W = 7;
  localparam int CTRL_POST_LSB = 0;
  localparam int POST_W = 4;
  localparam int MODE_W = 5;
  localparam int SUB_W = 3;
  localparam int IRQ_W = 2;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int STATE_ARMED_BIT = 0;
  localparam int STATE_LEVEL_BIT = 1;
  localparam int SYNC_STAGES = 2;

  // ****************************************************
  // mode codes
  // ****************************************************
  localparam logic [1:0] FAM_FREE = 2'h0;
  localparam logic [1:0] FAM_ONE = 2'h1;
  localparam logic [1:0] FAM_MONO = 2'h2;
  localparam logic [2:0] SUB_SW = 3'h0;
  localparam logic [2:0] SUB_RISE = 3'h1;
  localparam logic [2:0] SUB_FALL = 3'h2;
  localparam logic [2:0] SUB_ANY = 3'h3;
  localparam logic [2:0] SUB_RISE_RST = 3'h4;
  localparam logic [2:0] SUB_FALL_RST = 3'h5;
  localparam logic [2:0] SUB_RISE_LO = 3'h6;
  localparam logic [2:0] SUB_FALL_HI = 3'h7;

  // ****************************************************
  // reset values, bus answers, trigger timing
  // ****************************************************
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int EDGE_GAP_TICKS = 6;
  localparam int LEVEL_HOLD_TICKS = 3;

endpackage : tos_pkg

`default_nettype wire

// File: inc/tos_tick_if.sv
`default_nettype none

// prescaled tick and trigger events shared by the timer parts
interface tos_tick_if;
  logic tick;
  logic clear;
  logic flush;
  logic rise_pend;
  logic fall_pend;
  logic level;

  modport pre (input clear, output tick);
  modport edg (input tick, input flush, output rise_pend, output fall_pend, output level);
  modport core (input tick, input rise_pend, input fall_pend, input level,
                output clear, output flush);
endinterface : tos_tick_if

`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none

// ****************************************************
// bench top
// ****************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ext, pulse, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [4:0] modes[12] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
                            5'h11, 5'h12, 5'h13, 5'h16, 5'h17};
  logic [4:0] resv[4] = '{5'h10, 5'h14, 5'h15, 5'h18};
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h4690_98c0;

  tos_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_trigger_signal(ext), .postscaled_pulse(pulse), .timer_irq(irq)
  );
  tos_trig_model u_trig (
    .aclk(aclk), .aresetn(aresetn), .want(want), .slow(slow), .ext_trigger_signal(ext)
  );

  always #25 aclk = ~aclk;

  task automatic cmp_val(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // write one word, answer stalled by a random few cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = tos_pkg::RESP_OKAY);
    int t;
    int dly;
    dly = $random(seed) & 3;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (t >= dly) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (t >= 100) n_mismatch++;
  endtask : wr

  // read one word and note the expected answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    int t;
    int dly;
    dly = $random(seed) & 3;
    rq.push_back({tos_pkg::RESP_OKAY, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (rvalid && rready) break;
      if (arready) arvalid <= 1'b0;
      if (t >= dly) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (t >= 100) n_mismatch++;
  endtask : rd

  task automatic wait_trig;
    int t;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (ext !== want && t < 50);
    if (t >= 50) n_mismatch++;
  endtask : wait_trig

  task automatic wait_pulse(output int t);
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (pulse !== 1'b1 && t < 300);
    if (t >= 300) n_mismatch++;
  endtask : wait_pulse

  // answers checked against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready && bq.size() > 0) begin
      cmp_val({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
    end
    if (rvalid && rready && rq.size() > 0) begin
      cmp_val({rresp, rdata}, rq.pop_front());
    end
  end

  // main sequence
  initial begin
    logic [31:0] per;
    logic idle;
    logic mono;
    int t;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tos_pkg::OFF_PERIOD, 32'h0000_00ff);
    rd(tos_pkg::OFF_COUNT, 32'h0000_0000);
    wr(8'h20, 32'h0000_0001, tos_pkg::RESP_SLVERR);
    foreach (modes[i]) begin
      per = ($random(seed) & 32'h0000_0007) | 32'h0000_0001;
      idle = modes[i][2:0] inside {3'h2, 3'h5, 3'h7};
      mono = modes[i][4:3] == 2'h2 && modes[i][2:0] < 3'h4;
      wr(tos_pkg::OFF_CTRL, 32'h0000_0000);
      slow <= per[1];
      want <= idle;
      wait_trig();
      wr(tos_pkg::OFF_COUNT, 32'h0000_0000);
      wr(tos_pkg::OFF_PERIOD, per);
      wr(tos_pkg::OFF_MODE, 32'(modes[i]));
      wr(tos_pkg::OFF_CTRL, 32'h0000_0080);
      rd(tos_pkg::OFF_COUNT, 32'h0000_0000);
      want <= !idle;
      wait_pulse(t);
      rd(tos_pkg::OFF_CTRL, mono ? 32'h0000_0080 : 32'h0000_0000);
      rd(tos_pkg::OFF_COUNT, 32'h0000_0000);
      if (mono) begin
        want <= idle;
        wait_trig();
        want <= !idle;
        wait_pulse(t);
      end
    end
    foreach (resv[j]) begin
      wr(tos_pkg::OFF_CTRL, 32'h0000_0000);
      wr(tos_pkg::OFF_COUNT, 32'h0000_0000);
      wr(tos_pkg::OFF_MODE, 32'(resv[j]));
      wr(tos_pkg::OFF_CTRL, 32'h0000_0080);
      want <= !want;
      wait_trig();
      want <= !want;
      wait_trig();
      rd(tos_pkg::OFF_COUNT, 32'h0000_0000);
    end
    wr(tos_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
    rd(tos_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    wr(tos_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    for (int k = 0; k < 16; k += 5) begin
      per = ($random(seed) & 32'h0000_0003) | 32'h0000_0001;
      wr(tos_pkg::OFF_CTRL, 32'h0000_0000);
      wr(tos_pkg::OFF_COUNT, 32'h0000_0000);
      wr(tos_pkg::OFF_MODE, 32'h0000_0000);
      wr(tos_pkg::OFF_PERIOD, per);
      wr(tos_pkg::OFF_CTRL, 32'h0000_0080 | k);
      wait_pulse(t);
      wait_pulse(t);
      cmp_val(34'(t), 34'((per + 1) * (k + 1)));
    end
    cmp_val({33'h0_0000_0000, irq}, 34'h0_0000_0001);
    rd(tos_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    wr(tos_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    @(posedge aclk);
    cmp_val({33'h0_0000_0000, irq}, 34'h0_0000_0000);
    wr(tos_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (8) @(posedge aclk);
    wr(tos_pkg::OFF_IRQ_CLEAR, 32'h0000_0003);
    rd(tos_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    #(20000 * 50);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire

// File: tb/tos_timer_sva.sv
`default_nettype none

// ****************************************************
// port checks of the timer
// ****************************************************
module tos_timer_chk #(
  parameter int CNT_W = tos_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tos_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic postscaled_pulse,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] en_q;

  // shadow of the interrupt enable as written on the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 2'h0;
    end else if (awvalid && awready && wvalid && wready && wstrb[0] &&
                 awaddr == tos_pkg::OFF_IRQ_ENABLE) begin
      en_q <= wdata[1:0];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ans;
    !awready && !wready ##1 bvalid;
  endsequence

  AST_RST_IDLE:
    assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !timer_irq)
    else $error("bus or interrupt active after reset");
  AST_WR_ANSWER:
    assert property (s_wr |=> s_ans) else $error("write answer late");
  AST_WR_UNMAPPED:
    assert property (s_wr ##0 (awaddr > tos_pkg::OFF_STATE) |-> ##2
                     bvalid && bresp == tos_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_RD_ANSWER:
    assert property (arvalid && arready |=> rvalid && !arready) else $error("read answer late");
  AST_B_HOLD:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_R_HOLD:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  AST_PULSE_ONE:
    assert property (postscaled_pulse |=> !postscaled_pulse) else $error("pulse too wide");
  AST_IRQ_FWD:
    assert property (postscaled_pulse && en_q[0] |-> ##[2:4] timer_irq)
    else $error("enabled interrupt not raised");
  AST_IRQ_MASK:
    assert property ((en_q == 2'h0) [*4] |-> !timer_irq) else $error("masked interrupt raised");
endmodule : tos_timer_chk

bind tos_timer tos_timer_chk #(.CNT_W(CNT_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .postscaled_pulse(postscaled_pulse),
  .timer_irq(timer_irq)
);

`default_nettype wire

// File: tb/tos_trig_model.sv
`default_nettype none

// ****************************************************
// trigger source facing the timer
// ****************************************************
module tos_trig_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic want,
  input wire logic slow,
  output logic ext_trigger_signal
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_q;

  // new level only after the spacing ran out; slow doubles it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_trigger_signal <= 1'b0;
      gap_q <= 0;
    end else if (want != ext_trigger_signal &&
                 gap_q >= (slow ? 2 : 1) * tos_pkg::EDGE_GAP_TICKS) begin
      ext_trigger_signal <= want;
      gap_q <= 0;
    end else if (gap_q < 100) begin
      gap_q <= gap_q + 1;
    end
  end
endmodule : tos_trig_model

`default_nettype wire
